// >>> rtl/esiu_edge.sv
// Rising edge detector for internal same-clock event lines
`timescale 1ns/1ps
module esiu_edge
  import esiu_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Event levels
  input  wire logic [5:0] ev,
  // One cycle rise pulses
  output logic      [5:0] rise
);
  typedef struct packed {
    logic [5:0] prev;
  } esiu_edge_type;
  esiu_edge_type st_ff, nxt_st;
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = ev;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign rise = ev & ~st_ff.prev;
endmodule : esiu_edge

// >>> rtl/esiu_pkg.sv
// Package of register map, field positions and vectors for the eight source interrupt unit
package esiu_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_SAVED_FLAGS    = 8'hcf;
  localparam logic [7:0] ADDR_SYSTEM_CONTROL = 8'hd5;
  localparam logic [7:0] ADDR_CLOCK_EXT      = 8'hd6;
  localparam logic [7:0] ADDR_THIRD_TIMER    = 8'hd9;
  localparam logic [7:0] ADDR_INT_MASK       = 8'hfd;
  localparam logic [7:0] ADDR_INT_REQUEST    = 8'hfe;
  localparam logic [7:0] ADDR_PROC_FLAGS     = 8'hff;
  // Field positions
  localparam int GIE_BIT            = 0;
  localparam int EDGE1_BIT          = 0;
  localparam int EDGE2_BIT          = 1;
  localparam int THIRD_TIMER_ON_BIT = 7;
  localparam int HEARTBEAT_ON_BIT   = 6;
  localparam int SRC_TIMER1         = 0;
  localparam int SRC_TIMER2         = 1;
  localparam int SRC_FILTER         = 2;
  localparam int SRC_PIN1           = 3;
  localparam int SRC_TIMER3         = 4;
  localparam int SRC_BLOCK          = 5;
  localparam int SRC_PIN2           = 6;
  localparam int SRC_HEARTBEAT      = 7;
  // Reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  // Vector step and width
  localparam logic [15:0] VEC_STEP = 16'h0004;
  localparam int          VEC_W    = 20;
  localparam int          NSRC     = 8;
  // Lowest set bit index, used for priority and vector
  function automatic logic [2:0] esiu_lowest(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : esiu_lowest
endpackage : esiu_pkg

// >>> rtl/esiu_sync.sv
// Two stage synchroniser with edge detector for one external pin
`timescale 1ns/1ps
module esiu_sync
  import esiu_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Pin and polarity
  input  wire logic pin,
  input  wire logic falling,
  // Edge matching the polarity
  output logic      hit
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } esiu_sync_type;
  esiu_sync_type st_ff, nxt_st;
  // First stage feeds only the second
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = pin;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // Edge chosen by polarity; 0 rising, 1 falling
  assign hit = falling ? (st_ff.s3 & ~st_ff.s2) : (~st_ff.s3 & st_ff.s2);
endmodule : esiu_sync

// >>> rtl/esiu_top.sv
// Eight source interrupt unit: request latching, masking, flag save and vector supply
//
// Overview of operation
// R1: Eight sources, each with its own mask bit and request bit.
// R2: Internal sources latch on rising edge; pins use programmable edge.
// R3: Mask bits map 7 heartbeat down to 0 first timer.
// R4: Request register holds one pending flag per source, same layout.
// R5: Interrupt taken only when request, mask and global enable all set.
// R6: On accept copy flags to saved flags, then clear global enable.
// R7: Return from interrupt reloads flags from saved flags.
// R8: Saved flags readable and writable by software at its address.
// R9: Interrupt during enable-clearing instruction restores global enable as zero.
// R10: System control bits 1:0 pick pin edge, 0 rising, 1 falling.
// R11: Software driven pin transitions also raise pin requests.
// R12: Masked requests still latch and read back for polling.
// R13: Writing 0 clears a request flag; writing 1 does nothing.
// R14: Accepting an interrupt leaves its request flag set.
// R15: Vector for request n is four times n plus four.
// R16: Vector is 20 bits; high nibble follows code bank, untouched.
// R17: Second timer overflow latches its request even in idle.
// R18: Wakeup only if second timer flag was clear before power down.
// R19: Third timer and heartbeat timer stop when their on bits are 0.
// R20: Reset clears global enable; execution starts at address zero.
// R21: Lowest numbered enabled pending request is serviced first.
// R22: Pin levels pass two flip-flops before edge detection.
`timescale 1ns/1ps
module esiu_top
  import esiu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Event sources from timers and technology blocks
  input  wire logic        timer1_ovf,
  input  wire logic        timer2_ovf,
  input  wire logic        timer3_ovf,
  input  wire logic        heartbeat_ovf,
  input  wire logic        filter_end,
  input  wire logic        block_end,
  // External pins, already resolved to wire level
  input  wire logic        first_external_pin,
  input  wire logic        second_external_pin,
  // Processor core handshake
  input  wire logic        int_ack,
  input  wire logic        return_from_interrupt,
  input  wire logic        gie_clear_op,
  input  wire logic [3:0]  code_bank,
  input  wire logic        power_down,
  // To processor core and timers
  output logic             int_req,
  output logic [VEC_W-1:0] int_vector,
  output logic             timer2_wakeup,
  output logic             third_timer_on,
  output logic             heartbeat_clock_on
);
  typedef struct packed {
    logic [7:0]       saved_flags;
    logic [7:0]       system_control;
    logic [7:0]       clock_extension;
    logic [7:0]       third_timer_control;
    logic [7:0]       interrupt_mask;
    logic [7:0]       interrupt_request;
    logic [7:0]       processor_flags;
    logic [7:0]       rdata;
    logic             req;
    logic [VEC_W-1:0] vector;
    logic             t2_armed;
    logic             wake;
    logic             pdn_prev;
  } esiu_state_type;

  esiu_state_type st_ff, nxt_st;
  logic           pin1_hit;
  logic           pin2_hit;
  logic [5:0]     rise;
  logic [7:0]     events;
  logic [7:0]     pending;
  logic [2:0]     winner;

  // Synchronised pin edges; pin writes by software arrive on the same wire
  esiu_sync u_pin1 (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pin     (first_external_pin),
    .falling (st_ff.system_control[EDGE1_BIT]),
    .hit     (pin1_hit)
  ); // [R22] [R10] [R11]
  esiu_sync u_pin2 (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pin     (second_external_pin),
    .falling (st_ff.system_control[EDGE2_BIT]),
    .hit     (pin2_hit)
  ); // [R22] [R10] [R11]

  // Internal sources share one rising edge detector
  esiu_edge u_edge (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ev      ({heartbeat_ovf, block_end, timer3_ovf, filter_end, timer2_ovf, timer1_ovf}),
    .rise    (rise)
  ); // [R2]

  // Collect events in request bit order
  always_comb begin
    events                = '0;
    events[SRC_TIMER1]    = rise[0];
    events[SRC_TIMER2]    = rise[1]; // [R17]
    events[SRC_FILTER]    = rise[2];
    events[SRC_PIN1]      = pin1_hit;
    events[SRC_TIMER3]    = rise[3];
    events[SRC_BLOCK]     = rise[4];
    events[SRC_PIN2]      = pin2_hit;
    events[SRC_HEARTBEAT] = rise[5]; // [R3] [R4]
  end

  // Pending set is request gated by mask; global enable gates only the request line
  assign pending = st_ff.interrupt_request & st_ff.interrupt_mask; // [R5] [R12]
  assign winner  = esiu_lowest(pending); // [R21]

  // Next state: register writes, request latching, accept and return
  always_comb begin
    logic [7:0] req_next;
    logic       wr_hit;
    req_next = st_ff.interrupt_request;
    wr_hit   = 1'b0;
    nxt_st   = st_ff;
    nxt_st.pdn_prev = power_down;
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_SAVED_FLAGS: begin
          nxt_st.saved_flags = reg_wdata; // [R8]
        end
        ADDR_SYSTEM_CONTROL: begin
          nxt_st.system_control = reg_wdata;
        end
        ADDR_CLOCK_EXT: begin
          nxt_st.clock_extension = reg_wdata;
        end
        ADDR_THIRD_TIMER: begin
          nxt_st.third_timer_control = reg_wdata;
        end
        ADDR_INT_MASK: begin
          nxt_st.interrupt_mask = reg_wdata; // [R1] [R3]
        end
        ADDR_INT_REQUEST: begin
          req_next = req_next & reg_wdata; // [R13]
          wr_hit   = 1'b1;
        end
        ADDR_PROC_FLAGS: begin
          nxt_st.processor_flags = reg_wdata;
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
    end
    // Hardware set wins over a clear in the same cycle
    req_next = req_next | events; // [R2] [R12] [R17]
    nxt_st.interrupt_request = req_next;
    // Accept: save flags, then drop global enable; request stays set
    if (int_ack && st_ff.req) begin
      nxt_st.saved_flags = st_ff.processor_flags; // [R6] [R14]
      if (gie_clear_op) begin
        nxt_st.saved_flags[GIE_BIT] = 1'b0; // [R9]
      end
      nxt_st.processor_flags[GIE_BIT] = 1'b0; // [R6]
    end else if (return_from_interrupt) begin
      nxt_st.processor_flags = st_ff.saved_flags; // [R7]
    end
    // Request line and vector toward the core
    nxt_st.req = (|pending) && nxt_st.processor_flags[GIE_BIT] && !(int_ack && st_ff.req); // [R5]
    nxt_st.vector = {code_bank, VEC_STEP * (16'(winner) + 16'h0001)}; // [R15] [R16]
    // Timer2 wakeup arming sampled at the entry into power down
    if (power_down && !st_ff.pdn_prev) begin
      nxt_st.t2_armed = ~st_ff.interrupt_request[SRC_TIMER2]; // [R18]
    end else if (!power_down) begin
      nxt_st.t2_armed = 1'b0;
    end
    nxt_st.wake = power_down && st_ff.t2_armed && events[SRC_TIMER2]; // [R18]
    // Read data, one cycle after the strobe
    nxt_st.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_SAVED_FLAGS:    nxt_st.rdata = st_ff.saved_flags; // [R8]
        ADDR_SYSTEM_CONTROL: nxt_st.rdata = st_ff.system_control;
        ADDR_CLOCK_EXT:      nxt_st.rdata = st_ff.clock_extension;
        ADDR_THIRD_TIMER:    nxt_st.rdata = st_ff.third_timer_control;
        ADDR_INT_MASK:       nxt_st.rdata = st_ff.interrupt_mask;
        ADDR_INT_REQUEST:    nxt_st.rdata = st_ff.interrupt_request; // [R12]
        ADDR_PROC_FLAGS:     nxt_st.rdata = st_ff.processor_flags;
        default:             nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset drops global enable
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0; // [R20]
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata          = st_ff.rdata;
  assign int_req            = st_ff.req;
  assign int_vector         = st_ff.vector;
  assign timer2_wakeup      = st_ff.wake;
  assign third_timer_on     = st_ff.third_timer_control[THIRD_TIMER_ON_BIT]; // [R19]
  assign heartbeat_clock_on = st_ff.clock_extension[HEARTBEAT_ON_BIT]; // [R19]
endmodule : esiu_top

// >>> test/eight_source_interrupt_unit_tb.sv
// Self-checking bench for the eight source interrupt unit
`timescale 1ns/1ps
module eight_source_interrupt_unit_tb
  import esiu_pkg::*;
;
  logic             clk_sys, sys_rst, reg_wr, reg_rd, int_ack, int_req, seen, rd_d, en;
  logic             return_from_interrupt, gie_clear_op, power_down, first_external_pin;
  logic             second_external_pin, timer2_wakeup, third_timer_on, heartbeat_clock_on;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata, evs, r;
  logic [3:0]       code_bank;
  logic [1:0]       lag;
  logic [VEC_W-1:0] int_vector, exp_vec;
  logic [7:0]       exp_q[$];
  int               fails, cmp_count;
  logic [7:0]       map[8] = '{8'hcf, 8'hd5, 8'hd6, 8'hd9, 8'hfd, 8'hfe, 8'hff, 8'h10};
  int               src[6] = '{0, 1, 2, 4, 5, 7};

  esiu_top u_esiu_top (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .timer1_ovf(evs[0]), .timer2_ovf(evs[1]), .filter_end(evs[2]), .timer3_ovf(evs[4]),
    .block_end(evs[5]), .heartbeat_ovf(evs[7]), .first_external_pin, .second_external_pin,
    .int_ack, .return_from_interrupt, .gie_clear_op, .code_bank, .power_down, .int_req,
    .int_vector, .timer2_wakeup, .third_timer_on, .heartbeat_clock_on);
  esiu_core_model u_esiu_core_model (.clk_sys, .sys_rst, .en, .lag, .int_req, .int_ack);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [19:0] s, input logic [19:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Each access ends one edge before the next may start, so no strobe is driven twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic pulse(input logic [7:0] m);
    @(posedge clk_sys);
    evs <= m;
    @(posedge clk_sys);
    evs <= 8'h00;
  endtask : pulse

  // Bounded wait for the core model's ack
  task automatic wait_ack();
    for (int i = 0; i < 20 && int_ack !== 1'b1; i++) @(negedge clk_sys);
    chk(20'(int_ack), 20'h1);
  endtask : wait_ack

  task automatic ret();
    @(posedge clk_sys);
    return_from_interrupt <= 1'b1;
    @(posedge clk_sys);
    return_from_interrupt <= 1'b0;
  endtask : ret

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_d) chk({12'h0, reg_rdata}, {12'h0, exp_q.pop_front()});
    if (int_ack) chk(int_vector, exp_vec);
    rd_d <= reg_rd;
  end

  initial begin
    {sys_rst, reg_wr, reg_rd, return_from_interrupt, gie_clear_op, power_down, en} = 7'h40;
    {first_external_pin, second_external_pin, rd_d, lag, evs, code_bank} = '0;
    {reg_addr, reg_wdata, exp_vec, fails, cmp_count} = '0;
    void'($urandom(80));
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (map[i]) rd(map[i], 8'h00);
    chk(20'(int_req), 20'h0);
    $display("reset test done");
    foreach (map[i]) if (i < 5) begin
      r = 8'($urandom);
      wr(map[i], r);
      rd(map[i], r);
    end
    wr(ADDR_THIRD_TIMER, 8'h80);
    wr(ADDR_CLOCK_EXT, 8'h40);
    // Look off the launching edge so the new register value has settled
    @(negedge clk_sys);
    chk(20'({third_timer_on, heartbeat_clock_on}), 20'h3);
    wr(ADDR_INT_MASK, 8'h00);
    $display("register test done");
    foreach (src[k]) begin
      wr(ADDR_INT_REQUEST, 8'h00);
      pulse(8'h01 << src[k]);
      wr(ADDR_INT_REQUEST, 8'hff);
      rd(ADDR_INT_REQUEST, 8'h01 << src[k]);
    end
    $display("source test done");
    wr(ADDR_INT_REQUEST, 8'h00);
    wr(ADDR_SYSTEM_CONTROL, 8'h03);
    for (int p = 0; p < 3; p++) begin
      if (p == 2) wr(ADDR_SYSTEM_CONTROL, 8'h00);
      if (p == 2) wr(ADDR_INT_REQUEST, 8'h00);
      @(posedge clk_sys);
      {first_external_pin, second_external_pin} <= (p == 1) ? 2'b00 : 2'b11;
      repeat (8) @(posedge clk_sys);
      rd(ADDR_INT_REQUEST, (p == 0) ? 8'h00 : 8'h48);
    end
    $display("pin test done");
    wr(ADDR_INT_REQUEST, 8'h00);
    code_bank <= 4'($urandom);
    exp_vec <= 20'h0000c;
    wr(ADDR_INT_MASK, 8'hff);
    exp_vec[19:16] <= code_bank;
    pulse(8'h14);
    rd(ADDR_INT_REQUEST, 8'h14);
    chk(20'(int_req), 20'h0);
    en <= 1'b1;
    lag <= 2'h2;
    wr(ADDR_PROC_FLAGS, 8'h01);
    wait_ack();
    rd(ADDR_SAVED_FLAGS, 8'h01);
    rd(ADDR_PROC_FLAGS, 8'h00);
    rd(ADDR_INT_REQUEST, 8'h14);
    gie_clear_op <= 1'b1;
    lag <= 2'h0;
    ret();
    wait_ack();
    en <= 1'b0;
    rd(ADDR_SAVED_FLAGS, 8'h00);
    wr(ADDR_SAVED_FLAGS, 8'h01);
    ret();
    rd(ADDR_PROC_FLAGS, 8'h01);
    @(negedge clk_sys);
    chk(20'(int_req), 20'h1);
    wr(ADDR_PROC_FLAGS, 8'h00);
    wr(ADDR_INT_REQUEST, 8'h00);
    $display("interrupt test done");
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_sys);
      power_down <= 1'b1;
      repeat (2) @(posedge clk_sys);
      pulse(8'h02);
      seen = 1'b0;
      repeat (6) begin
        @(negedge clk_sys);
        seen = seen | timer2_wakeup;
      end
      chk(20'(seen), 20'(j == 0));
      @(posedge clk_sys);
      power_down <= 1'b0;
    end
    rd(ADDR_INT_REQUEST, 8'h02);
    $display("wakeup test done");
    repeat (3) @(posedge clk_sys);
    conclude();
  end

  // Whole run needs well under this span
  initial begin
    #100000;
    fails++;
    conclude();
  end
endmodule : eight_source_interrupt_unit_tb

// >>> test/esiu_core_model.sv
// Processor core model that acknowledges interrupt requests
`timescale 1ns/1ps
module esiu_core_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Bench control, lag sets a prompt or slow answer
  input  wire logic       en,
  input  wire logic [1:0] lag,
  // Core handshake
  input  wire logic       int_req,
  output logic            int_ack
);
  logic [1:0] wait_ff;
  // Ack is a single pulse, given only while the request stands
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wait_ff <= 2'h0;
      int_ack <= 1'b0;
    end else begin
      int_ack <= en && int_req && !int_ack && wait_ff == lag;
      wait_ff <= (int_req && !int_ack && wait_ff != lag) ? wait_ff + 2'h1 : 2'h0;
    end
  end
endmodule : esiu_core_model

// >>> test/esiu_properties.sv
// Port level checker for the eight source interrupt unit
`timescale 1ns/1ps
module esiu_properties
  import esiu_pkg::*;
(
  // Clock and reset
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  // Register port
  input wire logic [7:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  // Core side
  input wire logic             int_ack,
  input wire logic             return_from_interrupt,
  input wire logic [3:0]       code_bank,
  input wire logic             int_req,
  input wire logic [VEC_W-1:0] int_vector,
  input wire logic             timer2_wakeup,
  input wire logic             third_timer_on,
  input wire logic             heartbeat_clock_on
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Vector stays inside the fixed table while requesting
  a_vec_table: assert property (int_req |-> int_vector[15:2] inside {[14'h1:14'h8]}
    && int_vector[1:0] == 2'h0) else $error("vector outside table");
  a_vec_bank: assert property (int_req |-> int_vector[19:16] == $past(code_bank))
    else $error("vector bank differs");
  a_ack_drops: assert property (int_ack && int_req |=> !int_req)
    else $error("request kept after ack");
  // Only an ack, a write or a return may withdraw a standing request
  a_req_holds: assert property (int_req && !int_ack && !reg_wr && !$past(reg_wr)
    && !return_from_interrupt && !$past(return_from_interrupt) |=> int_req) else $error("request lost");
  a_third_timer_on_set: assert property (reg_wr && reg_addr == ADDR_THIRD_TIMER
    |=> third_timer_on == $past(reg_wdata[THIRD_TIMER_ON_BIT])) else $error("third timer on wrong");
  a_third_timer_on_hold: assert property (!(reg_wr && reg_addr == ADDR_THIRD_TIMER) |=> $stable(third_timer_on))
    else $error("third timer on moved");
  a_hb_on_set: assert property (reg_wr && reg_addr == ADDR_CLOCK_EXT
    |=> heartbeat_clock_on == $past(reg_wdata[HEARTBEAT_ON_BIT])) else $error("heartbeat on wrong");
  a_wake_pulse: assert property (timer2_wakeup |=> !timer2_wakeup)
    else $error("wakeup not a pulse");
  // Main scenarios
  c_ack: cover property (int_ack && int_req);
  c_wake: cover property (timer2_wakeup);
  c_ret: cover property (return_from_interrupt ##[1:8] int_req);
endmodule : esiu_properties

bind esiu_top esiu_properties u_esiu_properties (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .int_ack, .return_from_interrupt, .code_bank, .int_req, .int_vector, .timer2_wakeup,
  .third_timer_on, .heartbeat_clock_on);
